// file: shared/apdl_pkg.sv
// Constants, types and the absent-bit table shared by the port direction block.
// Assumes a 32-bit AXI4-Lite register bus and seventeen 8-bit port groups.
package apdl_pkg;

  localparam int          NUM_GROUPS   = 17;
  localparam int          GROUP_W      = 8;
  localparam int          AXI_ADDR_W   = 12;
  localparam int          AXI_DATA_W   = 32;
  localparam int          DEFAULT_PINS = 64;
  localparam int          SMALL_PINS   = 64;
  localparam int          GROUP_A      = 10;

  // Register banks, one aligned word per group
  localparam logic [3:0]  BANK_DIR     = 4'h0;
  localparam logic [3:0]  BANK_ODR     = 4'h1;
  localparam logic [3:0]  BANK_PIN     = 4'h2;
  localparam logic [11:0] CFG_ADDR     = 12'h300;
  localparam int          BANK_MSB     = 11;
  localparam int          BANK_LSB     = 8;
  localparam int          GRP_MSB      = 7;
  localparam int          GRP_LSB      = 2;

  localparam logic [7:0]  DIR_RESET    = 8'h00;
  localparam logic [7:0]  ODR_RESET    = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Groups 4, 5, 6 and C never drive their pins
  localparam logic [16:0] INPUT_ONLY_GROUPS = 17'h01070;
  // Groups 5, 6, 8, C, F and G lose their direction register on small packages
  localparam logic [16:0] NO_DIR_GROUPS     = 17'h19160;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } apdl_drive_t;

  typedef enum logic [2:0] {KIND_DIR, KIND_ODR, KIND_PIN, KIND_CFG, KIND_NONE} apdl_kind_t;

  typedef struct packed {
    apdl_kind_t kind;
    logic [4:0] grp;
  } apdl_dec_t;

  // Bits of a group that have no package pin for a given pin count
  function automatic logic [7:0] absent_mask(input int pins, input int grp);
    logic [7:0] m;
    m = 8'h00;
    case (pins)
      120: case (grp)
        0: m = 8'h3C;  1: m = 8'h10;  3: m = 8'h30;  5: m = 8'hC0;
        10: m = 8'h40; 12: m = 8'h3F; 15: m = 8'h10;
        default: m = 8'h00;
      endcase
      112: case (grp)
        0: m = 8'h0C;  1: m = 8'h18;  2: m = 8'h60;  3: m = 8'h30;  5: m = 8'hC0;
        10: m = 8'h40; 12: m = 8'h3F; 15: m = 8'h03; 16: m = 8'h40;
        default: m = 8'h00;
      endcase
      100: case (grp)
        0: m = 8'h3C;  1: m = 8'h1C;  2: m = 8'h60;  3: m = 8'h30;  5: m = 8'hC0;
        10: m = 8'h40; 12: m = 8'h3F; 15: m = 8'h1F; 16: m = 8'h7F;
        default: m = 8'h00;
      endcase
      64: case (grp)
        0: m = 8'h3C;  1: m = 8'h1C;  2: m = 8'h63;  3: m = 8'h30;  8: m = 8'h07;
        9: m = 8'h61;  10: m = 8'h43; 13: m = 8'h07;
        default: m = 8'h00;
      endcase
      48: case (grp)
        0: m = 8'h3F;  1: m = 8'h1F;  2: m = 8'h63;  3: m = 8'h3E;  4: m = 8'h60;
        8: m = 8'h07;  9: m = 8'h7F;  10: m = 8'h73; 11: m = 8'h80; 13: m = 8'h07;
        default: m = 8'h00;
      endcase
      default: m = 8'h00;
    endcase
    return m;
  endfunction

endpackage

// file: core/apdl_port_dir.sv
// Port direction and output-data registers with absent-pin handling per package.
// Assumes an AXI4-Lite master on CORE_CLK and pin inputs from outside the clock domain.
`timescale 1ns/1ps
module apdl_port_dir #(
  parameter int PIN_COUNT = apdl_pkg::DEFAULT_PINS
) (
  input  wire logic                                   CORE_CLK,
  input  wire logic                                   SRST,
  input  wire logic [apdl_pkg::AXI_ADDR_W-1:0]        S_AXI_AWADDR,
  input  wire logic                                   S_AXI_AWVALID,
  output logic                                        S_AXI_AWREADY,
  input  wire logic [apdl_pkg::AXI_DATA_W-1:0]        S_AXI_WDATA,
  input  wire logic [3:0]                             S_AXI_WSTRB,
  input  wire logic                                   S_AXI_WVALID,
  output logic                                        S_AXI_WREADY,
  output logic [1:0]                                  S_AXI_BRESP,
  output logic                                        S_AXI_BVALID,
  input  wire logic                                   S_AXI_BREADY,
  input  wire logic [apdl_pkg::AXI_ADDR_W-1:0]        S_AXI_ARADDR,
  input  wire logic                                   S_AXI_ARVALID,
  output logic                                        S_AXI_ARREADY,
  output logic [apdl_pkg::AXI_DATA_W-1:0]             S_AXI_RDATA,
  output logic [1:0]                                  S_AXI_RRESP,
  output logic                                        S_AXI_RVALID,
  input  wire logic                                   S_AXI_RREADY,
  input  wire logic [apdl_pkg::NUM_GROUPS*8-1:0]      PIN_IN,
  output apdl_pkg::apdl_drive_t [apdl_pkg::NUM_GROUPS-1:0] PIN_DRIVE
);

  localparam int  NG    = apdl_pkg::NUM_GROUPS;
  localparam bit  SMALL = (PIN_COUNT <= apdl_pkg::SMALL_PINS);

  // Refuse pin counts other than 48, 64, 100, 112, 120 and 144; 144 has no absent-bit table
  if (!(PIN_COUNT == 48 || PIN_COUNT == 64 || PIN_COUNT == 100 ||
        PIN_COUNT == 112 || PIN_COUNT == 120 || PIN_COUNT == 144)) begin : g_bad_pins
    $error("PIN_COUNT must be 48, 64, 100, 112, 120 or 144");
  end

  logic [NG-1:0][7:0] absent;
  logic [NG-1:0][7:0] drive_ok;
  logic [NG-1:0][7:0] dir_q;
  logic [NG-1:0][7:0] odr_q;
  logic [NG-1:0][7:0] pin_meta_q;
  logic [NG-1:0][7:0] pin_sync_q;

  // Per-group static masks taken from the pin count
  for (genvar g = 0; g < NG; g++) begin : g_mask
    assign absent[g]   = apdl_pkg::absent_mask(PIN_COUNT, g);
    assign drive_ok[g] = apdl_pkg::INPUT_ONLY_GROUPS[g] ? 8'h00 : ~absent[g];
  end

  // Address decode shared by read and write paths
  function automatic apdl_pkg::apdl_dec_t decode(input logic [apdl_pkg::AXI_ADDR_W-1:0] a);
    apdl_pkg::apdl_dec_t d;
    logic [5:0]          grp;
    d.kind = apdl_pkg::KIND_NONE;
    grp    = a[apdl_pkg::GRP_MSB:apdl_pkg::GRP_LSB];
    d.grp  = grp[4:0];
    if (a[apdl_pkg::AXI_ADDR_W-1:2] == apdl_pkg::CFG_ADDR[apdl_pkg::AXI_ADDR_W-1:2]) begin
      d.kind = apdl_pkg::KIND_CFG;
    end else if (grp < 6'(NG)) begin
      case (a[apdl_pkg::BANK_MSB:apdl_pkg::BANK_LSB])
        apdl_pkg::BANK_DIR: begin
          // Small packages have no direction register in the NO_DIR_GROUPS groups
          if (!(SMALL && apdl_pkg::NO_DIR_GROUPS[grp[4:0]])) begin
            d.kind = apdl_pkg::KIND_DIR;
          end
        end
        apdl_pkg::BANK_ODR: d.kind = apdl_pkg::KIND_ODR;
        apdl_pkg::BANK_PIN: d.kind = apdl_pkg::KIND_PIN;
        default:            d.kind = apdl_pkg::KIND_NONE;
      endcase
    end
    return d;
  endfunction

  // Write channel state
  logic                               aw_have_q, w_have_q;
  logic                               aw_ready_q, w_ready_q, bvalid_q;
  logic [1:0]                         bresp_q;
  logic [apdl_pkg::AXI_ADDR_W-1:0]    aw_addr_q;
  logic [7:0]                         w_byte_q;
  logic                               w_lane_q;
  logic                               aw_take, w_take, do_write;
  logic                               aw_have_d, w_have_d, bvalid_d;
  apdl_pkg::apdl_dec_t                wdec;

  assign aw_take   = S_AXI_AWVALID & aw_ready_q;
  assign w_take    = S_AXI_WVALID & w_ready_q;
  assign do_write  = aw_have_q & w_have_q & ~bvalid_q;
  assign aw_have_d = (aw_have_q | aw_take) & ~do_write;
  assign w_have_d  = (w_have_q | w_take) & ~do_write;
  assign bvalid_d  = do_write | (bvalid_q & ~S_AXI_BREADY);
  assign wdec      = decode(aw_addr_q);

  // Address and data are taken in either order, the response follows both
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      aw_ready_q <= 1'b0;
      w_ready_q  <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= apdl_pkg::RESP_OKAY;
      aw_addr_q  <= '0;
      w_byte_q   <= 8'h00;
      w_lane_q   <= 1'b0;
    end else begin
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      aw_ready_q <= ~aw_have_d & ~bvalid_d;
      w_ready_q  <= ~w_have_d & ~bvalid_d;
      bvalid_q   <= bvalid_d;
      if (aw_take) begin
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_byte_q <= S_AXI_WDATA[7:0];
        w_lane_q <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        bresp_q <= (wdec.kind == apdl_pkg::KIND_NONE) ? apdl_pkg::RESP_SLVERR
                                                      : apdl_pkg::RESP_OKAY;
      end
    end
  end

  // Direction and data storage; absent bits keep what software parks in them
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      dir_q <= {NG{apdl_pkg::DIR_RESET}};
      odr_q <= {NG{apdl_pkg::ODR_RESET}};
    end else if (do_write && w_lane_q) begin
      if (wdec.kind == apdl_pkg::KIND_DIR) begin
        dir_q[wdec.grp] <= w_byte_q;
      end
      if (wdec.kind == apdl_pkg::KIND_ODR) begin
        odr_q[wdec.grp] <= w_byte_q;
      end
    end
  end

  // Two-flop synchroniser on the pin levels
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= PIN_IN;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Pin drive: absent and input-only bits are never driven, whatever is stored
  always_ff @(posedge CORE_CLK) begin
    for (int g = 0; g < NG; g++) begin
      if (SRST) begin
        PIN_DRIVE[g].level <= 8'h00;
        PIN_DRIVE[g].oe_n  <= 8'hFF;
      end else begin
        PIN_DRIVE[g].level <= odr_q[g];
        PIN_DRIVE[g].oe_n  <= ~(dir_q[g] & drive_ok[g]);
      end
    end
  end

  // Read channel: one read at a time, data one cycle after the address is taken
  logic                ar_ready_q, rvalid_q;
  logic [1:0]          rresp_q;
  logic [7:0]          rbyte_q;
  logic                ar_take, rvalid_d;
  apdl_pkg::apdl_dec_t rdec;

  assign ar_take  = S_AXI_ARVALID & ar_ready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~S_AXI_RREADY);
  assign rdec     = decode(S_AXI_ARADDR);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ar_ready_q <= 1'b0;
      rvalid_q   <= 1'b0;
      rresp_q    <= apdl_pkg::RESP_OKAY;
      rbyte_q    <= 8'h00;
    end else begin
      ar_ready_q <= ~rvalid_d;
      rvalid_q   <= rvalid_d;
      if (ar_take) begin
        rresp_q <= apdl_pkg::RESP_OKAY;
        case (rdec.kind)
          apdl_pkg::KIND_DIR: rbyte_q <= dir_q[rdec.grp];
          apdl_pkg::KIND_ODR: rbyte_q <= odr_q[rdec.grp];
          // Absent bits have no pin, so they read as zero
          apdl_pkg::KIND_PIN: rbyte_q <= pin_sync_q[rdec.grp] & ~absent[rdec.grp];
          apdl_pkg::KIND_CFG: rbyte_q <= 8'(PIN_COUNT);
          default: begin
            rbyte_q <= 8'h00;
            rresp_q <= apdl_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  assign S_AXI_AWREADY = aw_ready_q;
  assign S_AXI_WREADY  = w_ready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ar_ready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = {24'h000000, rbyte_q};

  // Checks on the behaviour above
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  // Flat views of the pin drive, so whole-port checks need no loop
  logic [NG*8-1:0] oe_n_flat;
  logic [NG*8-1:0] level_flat;
  for (genvar g = 0; g < NG; g++) begin : g_flat
    assign oe_n_flat[g*8 +: 8]  = PIN_DRIVE[g].oe_n;
    assign level_flat[g*8 +: 8] = PIN_DRIVE[g].level;
  end

  AST_DIR_OUTPUT: assert property (
    do_write && w_lane_q && wdec.kind == apdl_pkg::KIND_DIR
    |-> ##2 PIN_DRIVE[$past(wdec.grp, 2)].oe_n == ~($past(w_byte_q, 2) & drive_ok[$past(wdec.grp, 2)])
  ) else $error("Direction write did not reach the pin enables");

  AST_INPUT_ONLY: assert property (
    PIN_DRIVE[4].oe_n == 8'hFF && PIN_DRIVE[5].oe_n == 8'hFF &&
    PIN_DRIVE[6].oe_n == 8'hFF && PIN_DRIVE[12].oe_n == 8'hFF
  ) else $error("Input-only group drove a pin");

  AST_NO_DIR_REG: assert property (
    ar_take && SMALL && S_AXI_ARADDR[11:8] == apdl_pkg::BANK_DIR &&
    S_AXI_ARADDR[7:2] == 6'h08 |=> S_AXI_RVALID && S_AXI_RRESP == apdl_pkg::RESP_SLVERR
  ) else $error("Missing direction register answered OKAY");

  AST_PIN_CFG: assert property (
    ar_take && S_AXI_ARADDR[11:2] == apdl_pkg::CFG_ADDR[11:2]
    |=> S_AXI_RDATA == 32'(PIN_COUNT) && S_AXI_RRESP == apdl_pkg::RESP_OKAY
  ) else $error("Pin count readback wrong");

  AST_GROUP_A_48: assert property (
    PIN_COUNT == 48 |-> absent[apdl_pkg::GROUP_A] == 8'h73 &&
    (PIN_DRIVE[apdl_pkg::GROUP_A].oe_n & 8'h73) == 8'h73
  ) else $error("Group A absent bits wrong for 48 pins");

  AST_STORE_ODR: assert property (
    do_write && w_lane_q && wdec.kind == apdl_pkg::KIND_ODR
    |=> odr_q[$past(wdec.grp)] == $past(w_byte_q) ##1 PIN_DRIVE[$past(wdec.grp, 2)].level == $past(w_byte_q, 2)
  ) else $error("Output data write not stored");

  AST_BRESP_TIME: assert property (
    aw_take && w_take && !bvalid_q |-> ##2 S_AXI_BVALID
  ) else $error("Write response late");

  // Absent bits never drive, whatever software parked in them
  AST_ABSENT_UNDRIVEN: assert property (
    (oe_n_flat & absent) == absent
  ) else $error("Absent port bit drove its pin");

  AST_OE_FOLLOWS: assert property (
    !$past(SRST) |-> oe_n_flat == ~($past(dir_q) & drive_ok)
  ) else $error("Pin enables do not follow the direction bits");

  AST_LEVEL_FOLLOWS: assert property (
    !$past(SRST) |-> level_flat == $past(odr_q)
  ) else $error("Pin levels do not follow the output data");

  AST_DIR_READBACK: assert property (
    ar_take && rdec.kind == apdl_pkg::KIND_DIR
    |=> S_AXI_RRESP == apdl_pkg::RESP_OKAY &&
        S_AXI_RDATA == {24'h000000, $past(dir_q[rdec.grp])}
  ) else $error("Direction readback differs from stored bits");

  // A refused write answers SLVERR and leaves every stored bit alone
  AST_WRITE_REFUSED: assert property (
    do_write && wdec.kind == apdl_pkg::KIND_NONE
    |=> S_AXI_BVALID && S_AXI_BRESP == apdl_pkg::RESP_SLVERR &&
        $stable(dir_q) && $stable(odr_q)
  ) else $error("Refused write was stored or answered OKAY");

  // Handshake shape: a channel stays closed until its answer is taken
  AST_RVALID_TIME: assert property (
    ar_take |=> S_AXI_RVALID
  ) else $error("Read data late");

  AST_B_BLOCKS_AW: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY
  ) else $error("Write channel ready while a response is pending");

  AST_R_BLOCKS_AR: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY
  ) else $error("Read address ready while read data is pending");

endmodule // apdl_port_dir

// file: verif/absent_port_direction_logic_tb.sv
// Self-checking bench for the port direction block, built for the 48 pin package.
// Assumes the block's register map and bus timing; the AXI4-Lite master lives in here.
`timescale 1ns/1ps
module absent_port_direction_logic_tb;
  localparam int         PINS     = 48;
  localparam logic [7:0] A_ABSENT = 8'h73; // Group A bits 0, 1, 4, 5, 6 have no pin
  localparam logic [1:0] OK       = apdl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR      = apdl_pkg::RESP_SLVERR;

  logic        core_clk;
  logic        srst;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [135:0] pin_in;
  apdl_pkg::apdl_drive_t [apdl_pkg::NUM_GROUPS-1:0] pin_drive;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          no_dir [6] = '{5, 6, 8, 12, 15, 16};

  apdl_port_dir #(.PIN_COUNT(PINS)) dut (
    .CORE_CLK(core_clk), .SRST(srst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_IN(pin_in), .PIN_DRIVE(pin_drive)
  );

  // Free-running clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr_chk(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                        input logic [1:0] exp);
    bit done;
    done = 1'b0;
    @(posedge core_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check({30'h0, bresp}, {30'h0, exp});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Read: rready held high until rvalid is seen
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] d, input logic [1:0] exp);
    bit done;
    done = 1'b0;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        check(rdata, {24'h000000, d});
        check({30'h0, rresp}, {30'h0, exp});
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Pin drive is looked at once the register write has had time to reach it
  task automatic drv_chk(input int g, input logic [7:0] oe_n, input logic [7:0] lvl);
    repeat (2) @(posedge core_clk);
    #1;
    check({24'h000000, pin_drive[g].oe_n}, {24'h000000, oe_n});
    check({24'h000000, pin_drive[g].level}, {24'h000000, lvl});
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    pin_in = '0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    drv_chk(7, 8'hFF, 8'h00);
    rd_chk(12'h01C, 8'h00, OK);
    // Plain group with every pin present
    wr_chk(12'h01C, 8'hA5, 4'hF, OK);
    wr_chk(12'h11C, 8'h3C, 4'hF, OK);
    drv_chk(7, 8'h5A, 8'h3C);
    rd_chk(12'h01C, 8'hA5, OK);
    rd_chk(12'h11C, 8'h3C, OK);
    // Disabled lane must leave the stored value alone
    wr_chk(12'h01C, 8'h00, 4'h0, OK);
    rd_chk(12'h01C, 8'hA5, OK);
    // Input-only group keeps its bits but never drives
    wr_chk(12'h010, 8'hFF, 4'hF, OK);
    wr_chk(12'h110, 8'hFF, 4'hF, OK);
    drv_chk(4, 8'hFF, 8'hFF);
    rd_chk(12'h010, 8'hFF, OK);
    // Groups without a direction register on this package
    foreach (no_dir[i]) begin
      wr_chk(12'(4 * no_dir[i]), 8'hFF, 4'hF, ERR);
      rd_chk(12'(4 * no_dir[i]), 8'h00, ERR);
    end
    wr_chk(12'h120, 8'h00, 4'hF, OK);
    // Parking group A the way start-up software does
    wr_chk(12'h028, 8'hFF, 4'hF, OK);
    wr_chk(12'h128, 8'h00, 4'hF, OK);
    drv_chk(10, A_ABSENT, 8'h00);
    rd_chk(12'h028, 8'hFF, OK);
    rd_chk(12'h128, 8'h00, OK);
    // Absent bits read as zero even when the pad floats high
    pin_in[87:80] <= 8'hFF;
    pin_in[63:56] <= 8'h5A;
    repeat (4) @(posedge core_clk);
    rd_chk(12'h228, ~A_ABSENT, OK);
    rd_chk(12'h21C, 8'h5A, OK);
    wr_chk(12'h21C, 8'h00, 4'hF, OK);
    rd_chk(12'h300, 8'(PINS), OK);
    check(32'(apdl_pkg::DEFAULT_PINS), 32'h00000040);
    wr_chk(12'h400, 8'h11, 4'hF, ERR);
    rd_chk(12'h400, 8'h00, ERR);
    // Reset in mid-run clears stored bits and drive
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    drv_chk(7, 8'hFF, 8'h00);
    rd_chk(12'h01C, 8'h00, OK);
    give_verdict();
  end
endmodule // absent_port_direction_logic_tb
